// ---- sar_adc_pkg.sv ----
package sar_adc_pkg;
	localparam int RESULT_WIDTH = 16;
	localparam int HALF_WIDTH = 8;
	// conversion length in rising edges of the conversion clock
	localparam int CONV_EDGES = 16;
	localparam logic [4:0] CONV_EDGES_CNT = 5'h10;
	// host-side clock limits, for reference only
	localparam int CONV_CLK_MIN_KHZ = 25;
	localparam int CONV_CLK_MAX_KHZ = 10000;
	// least conversion-start low time, in the system clock
	localparam int SYS_CLK_MHZ = 40;
	localparam int START_LOW_NS = 20;
	localparam int START_LOW_CYCLES = (START_LOW_NS * SYS_CLK_MHZ + 999) / 1000;
	localparam logic [15:0] RESULT_RESET = 16'h0000;
	localparam logic [15:0] CODE_ZERO = 16'h0000;
	localparam logic [15:0] CODE_MIDSCALE = 16'h8000;
	localparam logic [15:0] CODE_BELOW_MID = 16'h7fff;
	localparam logic [15:0] CODE_FULL = 16'hffff;

	typedef enum {
		ST_SAMPLE,
		ST_ARMED,
		ST_CONVERT
	} conv_state_type;

	typedef struct packed {
		logic cs_n;
		logic rd_n;
		logic half_sel;
	} read_ctl_type;

	typedef struct packed {
		logic [15:0] data;
		logic [15:0] oe;
	} bus_drive_type;
endpackage

// ---- sar_readout_mux.sv ----
`timescale 1ns/10ps
module sar_readout_mux
	import sar_adc_pkg::*;
(
	input wire logic [15:0] i_result, // held result word
	input wire sar_adc_pkg::read_ctl_type i_ctl, // chip select, read, half select
	output sar_adc_pkg::bus_drive_type o_bus // pin values and enables
);
	always_comb begin
		o_bus.data = i_result; // R12
		if (i_ctl.half_sel) begin
			o_bus.data = {i_result[15:8], i_result[15:8]}; // R13
		end
		// drive only while both strobes are low
		if (!i_ctl.cs_n && !i_ctl.rd_n) begin
			o_bus.oe = 16'hffff; // R9
		end else begin
			o_bus.oe = 16'h0000; // R9
		end
	end
endmodule

// ---- sar_adc_parallel_readout.sv ----
`timescale 1ns/10ps
// Contract
// R1: host supplies conversion clock between 25kHz and 10MHz.
// R2: conversion clock may run continuously or be gated between conversions.
// R3: host pulls conversion start low at least 20ns with chip select low.
// R4: sample changes to hold on the falling edge of conversion start.
// R5: conversion begins on the first conversion clock rise after start falls.
// R6: sixteen rising conversion clock edges complete a conversion.
// R7: busy rises right after start falls, falls when conversion ends.
// R8: chip select must be low when start falls, else no conversion.
// R9: data pins driven only while chip select and read both low. The enables are registered, so driving starts and stops one system clock later.
// R10: host avoids reading from 125ns before to 10ns after start falls.
// R11: results are straight binary, zero 0000 up to full scale FFFF.
// R12: half select low gives full 16-bit word, msb on highest pin.
// R13: half select low gives bits 7..0, high gives bits 15..8 on low pins.
// R14: half select acts combinationally; read may stay low while it toggles. The pins are registered, so a toggle shows one system clock later.
// R15: held result replaced only when next conversion finishes and busy falls.
module sar_adc_parallel_readout
	import sar_adc_pkg::*;
#(
	parameter int RESULT_BITS = RESULT_WIDTH,
	parameter int CONV_EDGE_COUNT = CONV_EDGES
) (
	input wire logic i_clk, // 40 MHz system clock
	input wire logic i_rst_n, // synchronous reset, active low
	input wire logic i_ce, // clock enable, freezes state while low
	input wire logic i_conv_clk, // conversion clock level, sampled
	input wire logic i_conversion_start_n, // start, active low
	input wire logic i_cs_n, // chip select, active low
	input wire logic i_rd_n, // read strobe, active low
	input wire logic i_half_sel, // half-word select
	input wire logic [15:0] i_sar_code, // straight binary code from comparator array
	output logic o_hold, // sample-and-hold in hold
	output logic o_busy, // conversion in progress
	output logic [15:0] o_result_pins, // data pin values
	output logic [15:0] o_result_pins_oe // data pin enables, high drives
);
	import sar_adc_pkg::*;

	conv_state_type state_reg, state_next;
	logic start_n_reg, start_n_next;
	logic conv_clk_reg, conv_clk_next;
	logic [4:0] edge_cnt_reg, edge_cnt_next;
	logic busy_reg, busy_next;
	logic hold_reg, hold_next;
	logic [15:0] result_reg, result_next;
	logic [15:0] pins_reg, pins_oe_reg;
	read_ctl_type ctl;
	bus_drive_type bus;
	logic start_fall, clk_rise;

	assign start_fall = start_n_reg && !i_conversion_start_n;
	assign clk_rise = !conv_clk_reg && i_conv_clk;

	always_comb begin
		state_next = state_reg;
		start_n_next = i_conversion_start_n;
		conv_clk_next = i_conv_clk;
		edge_cnt_next = edge_cnt_reg;
		busy_next = busy_reg;
		hold_next = hold_reg;
		result_next = result_reg;
		case (state_reg)
			ST_SAMPLE: begin
				if (start_fall && !i_cs_n) begin // R8
					state_next = ST_ARMED;
					hold_next = 1'b1; // R4
					busy_next = 1'b1; // R7
					edge_cnt_next = 5'h00;
				end
			end
			ST_ARMED: begin
				// gated clock simply delays this edge
				if (clk_rise) begin // R2
					state_next = ST_CONVERT; // R5
					edge_cnt_next = 5'h01;
				end
			end
			ST_CONVERT: begin
				if (clk_rise) begin
					edge_cnt_next = edge_cnt_reg + 5'h01;
				end
				if (edge_cnt_reg == 5'(CONV_EDGE_COUNT)) begin // R6
					state_next = ST_SAMPLE;
					busy_next = 1'b0; // R7
					hold_next = 1'b0;
					result_next = i_sar_code; // R11 R15
				end
			end
			default: begin
				state_next = ST_SAMPLE;
			end
		endcase
	end

	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			state_reg <= ST_SAMPLE;
			start_n_reg <= 1'b1;
			conv_clk_reg <= 1'b0;
			edge_cnt_reg <= 5'h00;
			busy_reg <= 1'b0;
			hold_reg <= 1'b0;
			result_reg <= RESULT_RESET;
		end else if (i_ce) begin
			state_reg <= state_next;
			start_n_reg <= start_n_next;
			conv_clk_reg <= conv_clk_next;
			edge_cnt_reg <= edge_cnt_next;
			busy_reg <= busy_next;
			hold_reg <= hold_next;
			result_reg <= result_next;
		end
	end

	assign ctl = '{cs_n: i_cs_n, rd_n: i_rd_n, half_sel: i_half_sel};

	sar_readout_mux u_mux (
		.i_result(result_reg),
		.i_ctl(ctl),
		.o_bus(bus)
	);

	// pins registered so every output comes from a flip-flop
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			pins_reg <= 16'h0000;
			pins_oe_reg <= 16'h0000;
		end else if (i_ce) begin
			pins_reg <= bus.data; // R14
			pins_oe_reg <= bus.oe; // R9
		end
	end

	assign o_busy = busy_reg;
	assign o_hold = hold_reg;
	assign o_result_pins = pins_reg;
	assign o_result_pins_oe = pins_oe_reg;

	property p_start_busy;
		@(posedge i_clk) disable iff (!i_rst_n)
		(i_ce && state_reg == ST_SAMPLE && start_fall && !i_cs_n) |=> (busy_reg && hold_reg);
	endproperty
	a_start_busy: assert property (p_start_busy) else $error("busy not raised on start"); // R7

	property p_no_cs;
		@(posedge i_clk) disable iff (!i_rst_n)
		(i_ce && state_reg == ST_SAMPLE && start_fall && i_cs_n) |=>
			(!busy_reg && state_reg == ST_SAMPLE);
	endproperty
	a_no_cs: assert property (p_no_cs) else $error("conversion without chip select"); // R8

	property p_first_edge;
		@(posedge i_clk) disable iff (!i_rst_n)
		(i_ce && state_reg == ST_ARMED && clk_rise) |=>
			(state_reg == ST_CONVERT && edge_cnt_reg == 5'h01);
	endproperty
	a_first_edge: assert property (p_first_edge) else $error("cycle one not counted"); // R5

	property p_end_count;
		@(posedge i_clk) disable iff (!i_rst_n)
		$fell(busy_reg) |-> $past(edge_cnt_reg) == CONV_EDGES_CNT;
	endproperty
	a_end_count: assert property (p_end_count) else $error("busy fell at wrong edge count"); // R6

	property p_result_stable;
		@(posedge i_clk) disable iff (!i_rst_n)
		!$fell(busy_reg) |-> $stable(result_reg);
	endproperty
	a_result_stable: assert property (p_result_stable) else $error("result changed mid conversion"); // R15

	property p_oe;
		@(posedge i_clk) disable iff (!i_rst_n)
		(i_ce && (i_cs_n || i_rd_n)) |=> (o_result_pins_oe == 16'h0000);
	endproperty
	a_oe: assert property (p_oe) else $error("pins driven without read"); // R9

	property p_full_word;
		@(posedge i_clk) disable iff (!i_rst_n)
		(i_ce && !i_half_sel) ##1 $stable(result_reg) |-> o_result_pins == result_reg;
	endproperty
	a_full_word: assert property (p_full_word) else $error("full word wrong"); // R12

	property p_upper_half;
		@(posedge i_clk) disable iff (!i_rst_n)
		(i_ce && i_half_sel) ##1 $stable(result_reg) |-> o_result_pins[7:0] == result_reg[15:8];
	endproperty
	a_upper_half: assert property (p_upper_half) else $error("upper half wrong"); // R13

	property p_low_half;
		@(posedge i_clk) disable iff (!i_rst_n)
		(i_ce && !i_half_sel) ##1 $stable(result_reg) |-> o_result_pins[7:0] == result_reg[7:0];
	endproperty
	a_low_half: assert property (p_low_half) else $error("lower half wrong"); // R13

	property p_oe_on;
		@(posedge i_clk) disable iff (!i_rst_n)
		(i_ce && !i_cs_n && !i_rd_n) |=> (o_result_pins_oe == 16'hffff);
	endproperty
	a_oe_on: assert property (p_oe_on) else $error("pins not driven during read"); // R9

	property p_busy_state;
		@(posedge i_clk) disable iff (!i_rst_n)
		busy_reg == (state_reg != ST_SAMPLE);
	endproperty
	a_busy_state: assert property (p_busy_state) else $error("busy out of step with state"); // R7

	property p_hold_busy;
		@(posedge i_clk) disable iff (!i_rst_n)
		hold_reg == busy_reg;
	endproperty
	a_hold_busy: assert property (p_hold_busy) else $error("hold out of step with busy"); // R4

	property p_armed_wait;
		@(posedge i_clk) disable iff (!i_rst_n)
		(i_ce && state_reg == ST_ARMED && !clk_rise) |=>
			(state_reg == ST_ARMED && edge_cnt_reg == 5'h00);
	endproperty
	a_armed_wait: assert property (p_armed_wait) else $error("conversion began without edge"); // R5

	property p_count_step;
		@(posedge i_clk) disable iff (!i_rst_n)
		(i_ce && state_reg == ST_CONVERT && clk_rise && edge_cnt_reg != CONV_EDGES_CNT) |=>
			(edge_cnt_reg == $past(edge_cnt_reg) + 5'h01);
	endproperty
	a_count_step: assert property (p_count_step) else $error("edge not counted"); // R6

	property p_result_load;
		@(posedge i_clk) disable iff (!i_rst_n)
		$fell(busy_reg) |-> (result_reg == $past(i_sar_code));
	endproperty
	a_result_load: assert property (p_result_load) else $error("result not loaded at end"); // R15
endmodule

// ---- conv_clk_host.sv ----
`timescale 1ns/10ps
module conv_clk_host (
	input wire logic i_clk, // system clock
	input wire logic i_run, // gate, low parks the clock low
	output logic o_conv_clk // 10 MHz conversion clock
);
	logic [1:0] div_reg;
	logic [1:0] div_next;
	always_comb begin
		div_next = i_run ? div_reg + 2'h1 : 2'h0;
	end
	always_ff @(posedge i_clk) begin
		div_reg <= div_next;
	end
	assign o_conv_clk = div_reg[1];
endmodule

// ---- sar_adc_parallel_readout_tb.sv ----
`timescale 1ns/10ps
module sar_adc_parallel_readout_tb;
	import sar_adc_pkg::*;
	logic clk = 0, rst_n = 0, run = 0, st_n = 1, cs_n = 1, rd_n = 1, hs = 0;
	logic conv_clk, hold, busy;
	logic [15:0] code = 16'h0000, pins, oe, res = 16'h0000;
	logic [15:0] codes [4] = '{16'h0000, 16'h7fff, 16'hffff, 16'ha55a};
	int num_errors = 0, checked = 0;
	always #12.5 clk = ~clk;
	conv_clk_host u_host (.i_clk(clk), .i_run(run), .o_conv_clk(conv_clk));
	sar_adc_parallel_readout u_dut (.i_clk(clk), .i_rst_n(rst_n), .i_ce(1'b1),
		.i_conv_clk(conv_clk), .i_conversion_start_n(st_n), .i_cs_n(cs_n), .i_rd_n(rd_n),
		.i_half_sel(hs), .i_sar_code(code), .o_hold(hold), .o_busy(busy),
		.o_result_pins(pins), .o_result_pins_oe(oe));
	task tally_and_finish;
		$display("checked %0d errors %0d", checked, num_errors);
		if (num_errors == 0 && checked > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	task chk(input logic [15:0] got, input logic [15:0] exp);
		checked++;
		if (got !== exp) begin
			num_errors++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	// set read controls, let the pin register update, then compare
	task rd(input logic c, input logic r, input logic h, input logic [15:0] ep,
		input logic [15:0] eo);
		@(negedge clk);
		cs_n = c;
		rd_n = r;
		hs = h;
		repeat (2) @(negedge clk);
		chk(oe, eo);
		if (eo !== 16'h0000) chk(pins, ep);
	endtask
	// one start pulse, a read in mid-conversion, bounded wait for busy to fall
	task conv(input logic [15:0] c, input logic sel_n, input logic free);
		int n;
		@(negedge clk);
		rd_n = 1'b1;
		run = free;
		// bus quiet well ahead of the start edge
		repeat (6) @(negedge clk);
		code = c;
		cs_n = sel_n;
		run = 1'b1;
		st_n = 1'b0;
		@(negedge clk);
		st_n = 1'b1;
		chk({14'h0, hold, busy}, {14'h0, ~sel_n, ~sel_n});
		n = 1;
		while (busy === 1'b1 && n < 300) begin
			if (n == 20) begin
				cs_n = 1'b0;
				rd_n = 1'b0;
			end
			if (n == 23) chk(pins, res);
			@(negedge clk);
			n++;
		end
		rd_n = 1'b1;
		run = free;
		if (n >= 300) begin
			num_errors++;
			tally_and_finish();
		end else if (!sel_n) begin
			chk({15'h0, (n - 4 * CONV_EDGES) inside {[-1:2]}}, 16'h0001);
			res = c;
		end
	endtask
	initial begin
		repeat (10) @(negedge clk);
		rst_n = 1'b1;
		rd(0, 1, 0, 16'h0000, 16'h0000);
		rd(1, 0, 0, 16'h0000, 16'h0000);
		rd(1, 1, 0, 16'h0000, 16'h0000);
		rd(0, 0, 0, 16'h0000, 16'hffff);
		conv(CODE_MIDSCALE, 1'b0, 1'b0);
		rd(0, 0, 0, 16'h8000, 16'hffff);
		conv(16'h1234, 1'b1, 1'b0);
		rd(0, 0, 0, 16'h8000, 16'hffff);
		foreach (codes[i]) begin
			conv(codes[i], 1'b0, (i % 2 == 1));
			rd(0, 0, 0, codes[i], 16'hffff);
			rd(0, 0, 1, {codes[i][15:8], codes[i][15:8]}, 16'hffff);
			rd(0, 0, 0, codes[i], 16'hffff);
		end
		tally_and_finish();
	end
endmodule
